// ==== rtcd_timebase.sv ====
// Timebase divider, control registers, interrupts and storage access
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "rtcd_consts.svh"
module rtcd_timebase
    import rtcd_pkg::*;
#(
    parameter int          RAM_DEPTH = `RTCD_RAM_DEPTH,
    parameter logic [7:0]  IO_BASE   = `RTCD_IO_BASE_DEFAULT
) (
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_reset,
    // Host register port
    input  wire rtcd_bus_req_t i_bus,
    input  wire logic [7:0]    i_io_base,
    input  wire logic          i_io_base_load,
    output logic      [7:0]    o_rd_data,
    // Timebase sources
    input  wire logic          i_crystal_amp_input,
    input  wire logic          i_ext_timebase_clock_in,
    input  wire logic          i_ext_clk_select,
    output logic               o_crystal_amp_output,
    output logic               o_osc_enable,
    // Events
    output logic               o_seconds_tick,
    output logic               o_irq
);
    //======================================================================
    // Decode helpers
    function automatic rtcd_mode_t dv_mode(input logic [2:0] dv);
        if (dv == `RTCD_DV_NORMAL)                   dv_mode = RTCD_MODE_NORMAL;
        else if (dv[2:1] == `RTCD_DV_RST_HI)         dv_mode = RTCD_MODE_CHAIN_RST;
        else if (dv == `RTCD_DV_OSC_OFF)             dv_mode = RTCD_MODE_OSC_OFF;
        else                                         dv_mode = RTCD_MODE_HOLD;
    endfunction : dv_mode

    function automatic logic is_ram(input logic [7:0] idx);
        is_ram = (idx >= `RTCD_RAM_FIRST);
    endfunction : is_ram

    //======================================================================
    // State
    logic [7:0]  io_base;
    logic [6:0]  idx0;
    logic [6:0]  idx1;
    logic [2:0]  dv_host;
    logic [2:0]  dv_act;
    logic [3:0]  rate;
    logic [7:0]  crb;
    logic [2:0]  status;
    logic [14:0] div_cnt;
    logic [5:0]  seconds;
    logic [7:0]  alarm;
    logic        upd_done;
    logic        x_s1, x_s2, x_s3;
    logic        e_s1, e_s2, e_s3;
    logic        rd_valid;
    logic        rd_from_ram;
    logic [7:0]  rd_reg_q;
    logic [7:0]  ram_q;

    //======================================================================
    // Host address decode, the base may be moved at run time
    wire [7:0] port_off = i_bus.addr - io_base;
    wire       port_hit = (port_off < `RTCD_PORT_SPAN);
    wire [1:0] port_sel = port_off[1:0];
    wire       dat0_hit = port_hit && (port_sel == `RTCD_PORT_DAT0);
    wire       dat1_hit = port_hit && (port_sel == `RTCD_PORT_DAT1);
    wire       data_hit = dat0_hit || dat1_hit;
    wire [7:0] data_idx = dat1_hit ? {`RTCD_BANK1_BIT, idx1} : {1'b0, idx0};
    wire       data_wr  = i_bus.wr && data_hit;
    wire       data_rd  = i_bus.rd && data_hit;

    // Lock bits bar the storage of one bank each; they stay set until reset
    wire       locked   = dat1_hit ? crb[`RTCD_CRB_LOCK1] : crb[`RTCD_CRB_LOCK0];
    wire       ram_sel  = is_ram(data_idx);
    wire       ram_we   = data_wr && ram_sel && !locked;
    wire       ram_re   = data_rd && ram_sel && !locked;
    wire [7:0] ram_addr = data_idx - `RTCD_RAM_FIRST;

    wire wr_sec = data_wr && (data_idx == `RTCD_REG_SEC);
    wire wr_alm = data_wr && (data_idx == `RTCD_REG_ALM);
    wire wr_cra = data_wr && (data_idx == `RTCD_REG_CRA);
    wire wr_crb = data_wr && (data_idx == `RTCD_REG_CRB);
    wire rd_crc = data_rd && (data_idx == `RTCD_REG_CRC);

    //======================================================================
    // Timebase source: each pin has its own two-flop synchroniser
    always_ff @(posedge i_clk) begin
        x_s1 <= i_crystal_amp_input;
        x_s2 <= x_s1;
        e_s1 <= i_ext_timebase_clock_in;
        e_s2 <= e_s1;
        if (i_reset) begin
            x_s3 <= 1'b0;
            e_s3 <= 1'b0;
        end else begin
            x_s3 <= x_s2;
            e_s3 <= e_s2;
        end
    end

    // Mode decode of the active control field
    rtcd_mode_t mode;
    assign mode         = dv_mode(dv_act);
    wire   osc_on       = (mode != RTCD_MODE_OSC_OFF);
    wire   x_rise       = x_s2 && !x_s3;
    wire   e_rise       = e_s2 && !e_s3;
    wire   tb_tick      = osc_on && (i_ext_clk_select ? e_rise : x_rise);
    rtcd_mode_t host_mode;
    assign host_mode    = dv_mode(dv_host);
    // Leaving or entering oscillator-off is adopted at once: a stopped
    // timebase has no edge to wait for, so waiting for one would deadlock
    wire   adopt        = tb_tick || (host_mode == RTCD_MODE_OSC_OFF)
                          || !osc_on;
    wire   activate     = adopt && (host_mode == RTCD_MODE_NORMAL)
                          && (mode != RTCD_MODE_NORMAL);
    wire   running      = (mode == RTCD_MODE_NORMAL);
    wire   chain_rst    = (mode == RTCD_MODE_CHAIN_RST);

    //======================================================================
    // Divider chain: fifteen halving stages form one binary count
    wire [14:0] div_inc  = div_cnt + 15'h0001;
    wire        sec_tick = tb_tick && running && (div_cnt == `RTCD_DIV_TOP);

    // Periodic tap: rate r picks a window of 16-r stages, flag at mid-window
    logic [14:0] tap_mask;
    logic [14:0] tap_mid;
    always_comb begin
        tap_mask = 15'h0000;
        tap_mid  = 15'h0000;
        for (int k = 0; k < `RTCD_DIV_STAGES; k++) begin
            if (k < (16 - int'(rate))) begin
                tap_mask[k] = 1'b1;
            end
            if (k == (15 - int'(rate))) begin
                tap_mid[k] = 1'b1;
            end
        end
    end
    // Taps are phased from the activation preset, so the widest window
    // also gives its first flag half a period after activation
    wire [14:0] div_phase = div_inc - `RTCD_DIV_HALF;
    wire per_tick = tb_tick && running && (rate != `RTCD_RS_RESET_VAL)
                    && ((div_phase & tap_mask) == tap_mid);

    // Update in progress: raised a fixed number of ticks before wrap
    wire uip = running
               && (div_cnt > (`RTCD_DIV_TOP - 15'(`RTCD_UIP_LEAD_TICKS)));

    // Control field is adopted on a timebase edge, or at once when entering or leaving oscillator-off
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dv_act <= `RTCD_DV_RESET_VAL;
        end else if (adopt) begin
            dv_act <= dv_host;
        end
    end

    // Chain count: preset to half on activation, zero while held reset.
    // Activation wins over chain reset, so leaving reset still presets half
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            div_cnt <= 15'h0000;
        end else if (activate) begin
            div_cnt <= `RTCD_DIV_HALF;
        end else if (chain_rst) begin
            div_cnt <= 15'h0000;
        end else if (tb_tick && running) begin
            div_cnt <= div_inc;
        end
    end

    //======================================================================
    // Seconds counter and alarm compare one cycle after each update
    wire [5:0] sec_inc   = (seconds == `RTCD_SEC_LAST) ? 6'h00 : seconds + 6'h01;
    wire       alm_match = (alarm[7:6] == `RTCD_ALM_ANY) || (alarm[5:0] == seconds);
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            seconds  <= 6'h00;
            alarm    <= 8'h00;
            upd_done <= 1'b0;
        end else begin
            upd_done <= sec_tick;
            if (wr_sec) begin
                seconds <= i_bus.wdata[5:0];
            end else if (sec_tick) begin
                seconds <= sec_inc;
            end
            if (wr_alm) begin
                alarm <= i_bus.wdata;
            end
        end
    end

    //======================================================================
    // Status: periodic, alarm, update ended; set wins over read clear
    wire [2:0] stat_set  = {per_tick, upd_done && alm_match, upd_done};
    wire [2:0] stat_clr  = rd_crc ? 3'h7 : 3'h0;
    wire [2:0] next_stat = (status & ~stat_clr) | stat_set;
    wire [2:0] irq_mask  = {crb[`RTCD_CRB_PIE], crb[`RTCD_CRB_AIE], crb[`RTCD_CRB_UIE]};
    wire       irq_any   = |(status & irq_mask);
    assign o_irq         = irq_any;

    // Host-owned registers; lock bits can only be set
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            io_base <= IO_BASE;
            idx0    <= 7'h00;
            idx1    <= 7'h00;
            dv_host <= `RTCD_DV_RESET_VAL;
            rate    <= `RTCD_RS_RESET_VAL;
            crb     <= 8'h00;
            status  <= 3'h0;
        end else begin
            status <= next_stat;
            if (i_io_base_load) begin
                io_base <= i_io_base;
            end
            if (i_bus.wr && port_hit && port_sel == `RTCD_PORT_IDX0) begin
                idx0 <= i_bus.wdata[6:0];
            end
            if (i_bus.wr && port_hit && port_sel == `RTCD_PORT_IDX1) begin
                idx1 <= i_bus.wdata[6:0];
            end
            if (wr_cra) begin
                dv_host <= i_bus.wdata[`RTCD_CRA_DV_HI:`RTCD_CRA_DV_LO];
                rate    <= i_bus.wdata[`RTCD_CRA_RS_HI:`RTCD_CRA_RS_LO];
            end
            if (wr_crb) begin
                crb <= i_bus.wdata | {6'h00, crb[1:0]};
            end
        end
    end

    //======================================================================
    // Storage
    rtcd_ram #(
        .DEPTH   (RAM_DEPTH)
    ) u_ram (
        .i_clk   (i_clk),
        .i_we    (ram_we),
        .i_re    (ram_re),
        .i_addr  (ram_addr),
        .i_wdata (i_bus.wdata),
        .o_rdata (ram_q)
    );

    //======================================================================
    // Register read mux, captured in the strobe cycle
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (port_hit && port_sel == `RTCD_PORT_IDX0) begin
            rd_mux = {1'b0, idx0};
        end else if (port_hit && port_sel == `RTCD_PORT_IDX1) begin
            rd_mux = {1'b0, idx1};
        end else if (data_hit && ram_sel && locked) begin
            rd_mux = `RTCD_LOCKED_READ;
        end else if (data_hit) begin
            unique case (data_idx)
                `RTCD_REG_SEC: rd_mux = {2'h0, seconds};
                `RTCD_REG_ALM: rd_mux = alarm;
                `RTCD_REG_CRA: rd_mux = {uip, dv_host, rate};
                `RTCD_REG_CRB: rd_mux = crb;
                `RTCD_REG_CRC: rd_mux = {irq_any, status, 4'h0};
                `RTCD_REG_CRD: rd_mux = `RTCD_CRD_VRT;
                default:       rd_mux = 8'h00;
            endcase
        end
    end

    // Read data stand one cycle only; the slave never stalls
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rd_valid    <= 1'b0;
            rd_from_ram <= 1'b0;
            rd_reg_q    <= 8'h00;
        end else begin
            rd_valid    <= i_bus.rd;
            rd_from_ram <= ram_re;
            rd_reg_q    <= rd_mux;
        end
    end
    assign o_rd_data = !rd_valid ? 8'h00 : (rd_from_ram ? ram_q : rd_reg_q);

    //======================================================================
    // Oscillator and tick outputs from flops
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_crystal_amp_output <= 1'b0;
            o_osc_enable         <= 1'b0;
            o_seconds_tick       <= 1'b0;
        end else begin
            o_crystal_amp_output <= osc_on && !x_s2;
            o_osc_enable         <= osc_on;
            o_seconds_tick       <= sec_tick;
        end
    end

    //======================================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Most expected values here are constants from the rules, but a_uip_before_tick, a_ctl_on_edge,
    // a_chain_held_zero, a_no_tick_stopped and a_osc_off_prompt reuse decode expressions above, so those can hide a broken one

    sequence s_activate;
        activate;
    endsequence
    sequence s_half_set;
        div_cnt == `RTCD_DIV_HALF;
    endsequence

    a_chain_held_zero: assert property (
        chain_rst && !activate |=> div_cnt == 15'h0000 && !sec_tick)
        else $error("divider not held at zero in chain reset");
    a_activate_half: assert property (s_activate |=> s_half_set)
        else $error("activation did not preset half count");
    a_tick_at_wrap: assert property (
        sec_tick |=> div_cnt == 15'h0000 && o_seconds_tick)
        else $error("seconds tick without wrap");
    a_uip_before_tick: assert property (sec_tick |-> uip && $past(uip))
        else $error("update flag not raised ahead of update");
    a_ctl_on_edge: assert property ($changed(dv_act) |-> $past(tb_tick) || $past(!osc_on)
                                    || $past(host_mode == RTCD_MODE_OSC_OFF))
        else $error("control field adopted off a timebase edge");
    a_lock_blocks: assert property (
        data_rd && ram_sel && locked |=> o_rd_data == `RTCD_LOCKED_READ)
        else $error("locked storage not read as all ones");
    a_stat_sticky: assert property (upd_done |=> status[0])
        else $error("update flag lost");
    a_no_tick_stopped: assert property (!osc_on |-> !tb_tick ##1 !o_osc_enable)
        else $error("timebase ran with oscillator stopped");
    a_sec_advance: assert property (
        sec_tick && !wr_sec && seconds != `RTCD_SEC_LAST |=> seconds == $past(seconds) + 6'h01)
        else $error("seconds not advanced on update");
    a_sec_wrap: assert property (
        sec_tick && !wr_sec && seconds == `RTCD_SEC_LAST |=> seconds == 6'h00)
        else $error("seconds did not wrap after the last value");
    a_osc_off_prompt: assert property (
        host_mode == RTCD_MODE_OSC_OFF |=> mode == RTCD_MODE_OSC_OFF)
        else $error("oscillator stop not taken at once");
    a_read_clears: assert property (
        rd_crc && !per_tick && !upd_done |=> status == 3'h0)
        else $error("status not cleared by read");

endmodule : rtcd_timebase

// ==== rtcd_consts.svh ====
// Constants for the real-time clock timebase divider block
//==========================================================================
//==========================================================================
`ifndef RTCD_CONSTS_SVH
`define RTCD_CONSTS_SVH

//==========================================================================
// Host port map, offsets from the relocatable base
`define RTCD_IO_BASE_DEFAULT 8'h70
`define RTCD_PORT_SPAN       8'h04
`define RTCD_PORT_IDX0       2'h0
`define RTCD_PORT_DAT0       2'h1
`define RTCD_PORT_IDX1       2'h2
`define RTCD_PORT_DAT1       2'h3

//==========================================================================
// Register indexes
`define RTCD_REG_SEC         8'h00
`define RTCD_REG_ALM         8'h01
`define RTCD_REG_CRA         8'h0A
`define RTCD_REG_CRB         8'h0B
`define RTCD_REG_CRC         8'h0C
`define RTCD_REG_CRD         8'h0D
`define RTCD_RAM_FIRST       8'h0E
`define RTCD_RAM_DEPTH       242
`define RTCD_BANK1_BIT       1'h1
`define RTCD_LOCKED_READ     8'hFF

//==========================================================================
// Fields and reset values
`define RTCD_CRA_UIP         7
`define RTCD_CRA_DV_HI       6
`define RTCD_CRA_DV_LO       4
`define RTCD_CRA_RS_HI       3
`define RTCD_CRA_RS_LO       0
`define RTCD_CRB_PIE         6
`define RTCD_CRB_AIE         5
`define RTCD_CRB_UIE         4
`define RTCD_CRB_LOCK1       1
`define RTCD_CRB_LOCK0       0
`define RTCD_CRC_IRQF        7
`define RTCD_CRC_PF          6
`define RTCD_CRC_AF          5
`define RTCD_CRC_UF          4
`define RTCD_CRD_VRT         8'h80
`define RTCD_DV_OSC_OFF      3'h0
`define RTCD_DV_NORMAL       3'h2
`define RTCD_DV_RST_HI       2'h3
`define RTCD_DV_RESET_VAL    3'h0
`define RTCD_RS_RESET_VAL    4'h0
`define RTCD_ALM_ANY         2'h3
`define RTCD_SEC_LAST        6'h3B

//==========================================================================
// Divider and timing
`define RTCD_DIV_STAGES      15
`define RTCD_DIV_HALF        15'h4000
`define RTCD_DIV_TOP         15'h7FFF
`define RTCD_TB_HZ           32768
`define RTCD_UIP_LEAD_US     244
`define RTCD_UIP_LEAD_TICKS  ((`RTCD_UIP_LEAD_US * `RTCD_TB_HZ + 999999) / 1000000)

`endif

// ==== rtcd_pkg.sv ====
// Types shared by the real-time clock timebase divider files
//==========================================================================
package rtcd_pkg;

    // One host bus request as it arrives on the plain port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rtcd_bus_req_t;

    // Decoded divider control field
    typedef enum logic [1:0] {
        RTCD_MODE_OSC_OFF,
        RTCD_MODE_NORMAL,
        RTCD_MODE_CHAIN_RST,
        RTCD_MODE_HOLD
    } rtcd_mode_t;

endpackage : rtcd_pkg

// ==== rtcd_ram.sv ====
// General-purpose byte storage with registered read data
`timescale 1ns/1ps
`include "rtcd_consts.svh"
module rtcd_ram
    import rtcd_pkg::*;
#(
    parameter int DEPTH = `RTCD_RAM_DEPTH
) (
    // Clock
    input  wire logic       i_clk,
    // Access
    input  wire logic       i_we,
    input  wire logic       i_re,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem [DEPTH];

    // Contents are not reset: they model battery-retained bytes
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        if (i_re) begin
            o_rdata <= mem[i_addr];
        end
    end

endmodule : rtcd_ram

// ==== rtcd_timebase_test.sv ====
// Self-checking bench for the real-time clock timebase divider
`timescale 1ns/1ps
`include "rtcd_consts.svh"
module rtcd_timebase_test
    import rtcd_pkg::*;
();
    //==========================================================================
    // Signals
    logic          i_clk;
    logic          i_reset;
    rtcd_bus_req_t i_bus;
    logic [7:0]    i_io_base;
    logic          i_io_base_load;
    logic          tb_tck;
    logic          i_ext_clk_select;
    logic [7:0]    o_rd_data;
    logic          o_crystal_amp_output;
    logic          o_osc_enable;
    logic          o_seconds_tick;
    logic          o_irq;
    logic [7:0]    base;
    logic [7:0]    rdv;
    int            n_fail;
    int            check_count;
    int            cyc;
    int            t_act;
    int            n_sec;

    //==========================================================================
    // Design under test, both timebase inputs share one toggling source
    rtcd_timebase rtcd_timebase_inst (
        .i_clk                   (i_clk),
        .i_reset                 (i_reset),
        .i_bus                   (i_bus),
        .i_io_base               (i_io_base),
        .i_io_base_load          (i_io_base_load),
        .o_rd_data               (o_rd_data),
        .i_crystal_amp_input     (tb_tck),
        .i_ext_timebase_clock_in (tb_tck),
        .i_ext_clk_select        (i_ext_clk_select),
        .o_crystal_amp_output    (o_crystal_amp_output),
        .o_osc_enable            (o_osc_enable),
        .o_seconds_tick          (o_seconds_tick),
        .o_irq                   (o_irq)
    );

    //==========================================================================
    // Clocks: timebase runs at a quarter of i_clk so half a second fits the run
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    initial begin
        tb_tck = 1'b0;
        forever begin
            repeat (2) @(posedge i_clk);
            tb_tck <= ~tb_tck;
        end
    end

    // Cycle count and seconds tick count, sampled on the edge
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_seconds_tick === 1'b1) n_sec <= n_sec + 1;
    end

    //==========================================================================
    // Compare, bus and register tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Strobe dropped for one cycle so the next call never re-drives at the same edge
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus <= '0;
        @(posedge i_clk);
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus <= '0;
        #1 d = o_rd_data;
        @(posedge i_clk);
    endtask : bus_rd

    // Index bit 7 selects the second index/data pair
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        bus_wr(base + {6'h00, idx[7], 1'b0}, {1'b0, idx[6:0]});
        bus_wr(base + {6'h00, idx[7], 1'b1}, d);
    endtask : reg_wr

    task automatic reg_chk(input string what, input logic [7:0] idx, input logic [7:0] mask,
                           input logic [7:0] exp);
        bus_wr(base + {6'h00, idx[7], 1'b0}, {1'b0, idx[6:0]});
        bus_rd(base + {6'h00, idx[7], 1'b1}, rdv);
        chk(what, exp, rdv & mask);
    endtask : reg_chk

    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    //==========================================================================
    // Main sequence
    initial begin
        i_reset = 1'b1;
        i_bus = '0;
        i_io_base = 8'h70;
        i_io_base_load = 1'b0;
        i_ext_clk_select = 1'b1;
        base = 8'h70;
        n_fail = 0;
        check_count = 0;
        cyc = 0;
        n_sec = 0;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        // Reset state of registers and outputs
        reg_chk("cra reset", 8'h0A, 8'hFF, 8'h00);
        reg_chk("crb reset", 8'h0B, 8'hFF, 8'h00);
        reg_chk("crd value", 8'h0D, 8'hFF, 8'h80);
        chk("osc enable reset", 8'h00, {7'h00, o_osc_enable});
        // Storage in both banks, including the last byte
        reg_wr(8'h0E, 8'hA5);
        reg_wr(8'h80, 8'h5A);
        reg_wr(8'hFF, 8'h3C);
        reg_chk("ram first", 8'h0E, 8'hFF, 8'hA5);
        reg_chk("ram bank1", 8'h80, 8'hFF, 8'h5A);
        reg_chk("ram last", 8'hFF, 8'hFF, 8'h3C);
        bus_rd(8'h10, rdv);
        chk("unmapped read", 8'h00, rdv);
        // Relocate the port window; the old base must fall silent
        i_io_base <= 8'h20;
        i_io_base_load <= 1'b1;
        @(posedge i_clk);
        i_io_base_load <= 1'b0;
        @(posedge i_clk);
        base = 8'h20;
        reg_chk("crd relocated", 8'h0D, 8'hFF, 8'h80);
        bus_rd(8'h71, rdv);
        chk("old base read", 8'h00, rdv);
        // Activate from oscillator-off with rate 8: 256-tick period, flag after 128 ticks
        reg_wr(8'h0B, 8'h40);
        reg_wr(8'h0A, 8'h28);
        t_act = cyc;
        repeat (300) @(posedge i_clk);
        reg_chk("pf before half", 8'h0C, 8'hF0, 8'h00);
        chk("irq before half", 8'h00, {7'h00, o_irq});
        repeat (500) @(posedge i_clk);
        chk("irq periodic", 8'h01, {7'h00, o_irq});
        reg_chk("pf after half", 8'h0C, 8'hF0, 8'hC0);
        chk("irq after clear", 8'h00, {7'h00, o_irq});
        reg_chk("cra fields", 8'h0A, 8'h7F, 8'h28);
        chk("osc enable on", 8'h01, {7'h00, o_osc_enable});
        // Masked periodic flag still sets status but keeps the line low
        reg_wr(8'h0B, 8'h00);
        repeat (1200) @(posedge i_clk);
        chk("irq masked", 8'h00, {7'h00, o_irq});
        reg_chk("pf masked", 8'h0C, 8'h40, 8'h40);
        // First second half a second after activation, alarm on any second
        reg_wr(8'h01, 8'hC0);
        reg_wr(8'h0B, 8'h30);
        while (n_sec == 0 && cyc - t_act < 70000) @(posedge i_clk);
        if (n_sec == 0) begin
            n_fail++;
            $display("Error first tick expected 1 seen 0");
            wrap_up();
        end
        chk("first tick time", 8'h01,
            {7'h00, (cyc - t_act >= 65528) && (cyc - t_act <= 65560)});
        repeat (3) @(posedge i_clk);
        chk("irq update", 8'h01, {7'h00, o_irq});
        reg_chk("uf af", 8'h0C, 8'h70, 8'h70);
        reg_chk("seconds", 8'h00, 8'hFF, 8'h01);
        // Chain held reset: no ticks, no periodic flags
        reg_wr(8'h0A, 8'h68);
        repeat (50) @(posedge i_clk);
        reg_chk("crc clear", 8'h0C, 8'h30, 8'h00);
        repeat (2000) @(posedge i_clk);
        reg_chk("pf in reset", 8'h0C, 8'h40, 8'h00);
        chk("ticks in reset", 8'h01, n_sec[7:0]);
        reg_chk("dv chain reset", 8'h0A, 8'h70, 8'h60);
        // Oscillator stop turns the amplifier off at once
        reg_wr(8'h0A, 8'h08);
        repeat (10) @(posedge i_clk);
        chk("osc off", 8'h00, {6'h00, o_osc_enable, o_crystal_amp_output});
        // Lock of bank 0 storage leaves bank 1 readable
        reg_wr(8'h0B, 8'h01);
        reg_chk("locked read", 8'h0E, 8'hFF, 8'hFF);
        reg_chk("bank1 open", 8'h80, 8'hFF, 8'h5A);
        wrap_up();
    end
endmodule : rtcd_timebase_test
